/* common/ach_pkg.sv */
// Constants, timing counts and carrier types for the conversion handshake.
// Assumes a 100 MHz clock; every cycle count derived from ns below rests on it.
`default_nettype none
package ach_pkg;
  // Result and analog stand-in widths
  localparam int DATA_W = 14;
  localparam int CODE_COUNT = 16384;
  localparam int FRAC_W = 4;
  localparam int LEVEL_W = DATA_W + FRAC_W + 1;
  // One code step in nanovolts (305.2 uV)
  localparam int LSB_NV = 305200;
  // Timing figures as given, in ns
  localparam int CLK_NS = 10;
  localparam int CONV_TYP_NS = 330;
  localparam int CONV_MAX_NS = 400;
  localparam int ACQ_MIN_NS = 100;
  localparam int THRU_NS = 454;
  localparam int DATA_VALID_NS = 20;
  // Derived cycle counts
  localparam int CONV_CYC = (CONV_TYP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_NS;
  localparam int ACQ_CYC = (ACQ_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int THRU_CYC = THRU_NS / CLK_NS;
  localparam int VALID_CYC = (DATA_VALID_NS / CLK_NS < 1) ? 1 : DATA_VALID_NS / CLK_NS;
  // Synchroniser depth and pin-edge to accept latency
  localparam int SYNC_STAGES = 3;
  localparam int EDGE_LAT = SYNC_STAGES + 2;
  // Reset values
  localparam logic [DATA_W-1:0] RESULT_RST = 14'h0000;
  localparam logic START_IDLE = 1'b1;
  localparam logic BUSY_IDLE = 1'b1;

  typedef enum logic [0:0] {ACH_ACQUIRE, ACH_CONVERT} ach_state_e;

  typedef struct packed {
    logic clamped;
    logic [DATA_W-1:0] code;
  } ach_sample_s;

  typedef struct packed {
    logic busyN;
    logic [DATA_W-1:0] data;
  } ach_out_s;
endpackage : ach_pkg
`default_nettype wire

/* core/ach_start_sync.sv */
// Three-stage synchroniser with agreement filter for the start pin.
// Assumes the pin is asynchronous to clk; reports one falling edge pulse.
`timescale 1ns/1ps
`default_nettype none
module ach_start_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic pinN,
  output logic level,
  output logic fell
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s1 <= ach_pkg::START_IDLE;
      s2 <= ach_pkg::START_IDLE;
      s3 <= ach_pkg::START_IDLE;
    end
    else
    begin
      s1 <= pinN;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Change counts only once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      level <= ach_pkg::START_IDLE;
      fell <= 1'b0;
    end
    else
    begin
      if (s2 == s3)
        level <= s2;
      fell <= (s2 == s3) && level && !s2;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_fall_agreed: assert property (fell |-> $past(s2) == $past(s3) && !$past(s2))
    else $error("start fall reported without agreement");
  a_fall_single: assert property (fell |=> !fell)
    else $error("start fall pulse longer than one cycle");
endmodule : ach_start_sync
`default_nettype wire

/* core/ach_quantizer.sv */
// Behavioural quantiser: aligns the analog stand-in with the start
// synchroniser and rounds it to a two's complement code with clamping.
// Assumes analogLevel is signed, in steps of 1/16 code, driven on clk.
`timescale 1ns/1ps
`default_nettype none
module ach_quantizer #(
  parameter int DEPTH = ach_pkg::SYNC_STAGES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic signed [ach_pkg::LEVEL_W-1:0] analogLevel,
  output ach_pkg::ach_sample_s sample
);
  localparam int LW = ach_pkg::LEVEL_W;
  localparam logic signed [LW:0] HALF = (LW+1)'(1 << (ach_pkg::FRAC_W - 1));
  localparam logic signed [LW:0] MAXC = (LW+1)'((1 << (ach_pkg::DATA_W - 1)) - 1);
  localparam logic signed [LW:0] MINC = -MAXC - (LW+1)'(1);

  if (DEPTH < 1)
  begin : g_bad_depth
    $error("DEPTH must be at least one");
  end

  logic signed [LW-1:0] stage [DEPTH];
  logic signed [LW:0] rounded;
  logic signed [LW:0] whole;

  // Delay matches the start synchroniser so the code belongs to the edge
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_align
    always_ff @(posedge clk)
    begin
      if (reset)
        stage[i] <= '0;
      else if (i == 0)
        stage[i] <= analogLevel;
      else
        stage[i] <= stage[(i == 0) ? 0 : i - 1];
    end
  end

  // Round half up: transitions sit midway between code steps
  always_comb
  begin
    rounded = {stage[DEPTH-1][LW-1], stage[DEPTH-1]} + HALF;
    whole = rounded >>> ach_pkg::FRAC_W;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      sample <= '0;
    else if (whole > MAXC)
      sample <= {1'b1, MAXC[ach_pkg::DATA_W-1:0]};
    else if (whole < MINC)
      sample <= {1'b1, MINC[ach_pkg::DATA_W-1:0]};
    else
      sample <= {1'b0, whole[ach_pkg::DATA_W-1:0]};
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_clamp_top: assert property (whole > MAXC |=> sample.code == 14'h1fff)
    else $error("overrange did not clamp to top code");
  a_clamp_bottom: assert property (whole < MINC |=> sample.code == 14'h2000)
    else $error("underrange did not clamp to bottom code");
  a_round_half: assert property (
    stage[DEPTH-1][ach_pkg::FRAC_W-1:0] == 4'h8 && whole <= MAXC && whole >= MINC
    |=> sample.code == $past(stage[DEPTH-1][ach_pkg::FRAC_W +: ach_pkg::DATA_W]) + 14'h0001)
    else $error("half step did not round up");
endmodule : ach_quantizer
`default_nettype wire

/* core/ach_core.sv */
// Conversion handshake of a 14-bit sampling converter: start pin in,
// busy flag and parallel two's complement result out.
// Assumes one 100 MHz clock; the analog stand-in is driven on that clock.
//
// Contract
// - A falling start edge begins a conversion when none is running.
// - Start edges during a conversion are ignored; no restart.
// - Busy is low for the whole conversion, high otherwise.
// - New result loads onto the bus on the edge busy rises.
// - Result stable within 20 ns of busy rising; host samples no earlier.
// - Result is 14-bit two's complement, 16384 codes, 305.2 uV a step.
// - Pins are one start input, a 14-bit bus and one busy output.
// - The falling start edge fixes the sampling instant.
// - Conversion lasts typically 330 ns, never over 400 ns.
// - One acquire plus convert cycle every 454 ns is supported.
// - Code changes midway between steps, first at half a step up.
`timescale 1ns/1ps
`default_nettype none
module ach_core #(
  parameter int CONV_CYC = ach_pkg::CONV_CYC,
  parameter int SYNC_STAGES = ach_pkg::SYNC_STAGES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic conversionStartN,
  input wire logic signed [ach_pkg::LEVEL_W-1:0] analogLevel,
  output logic busyN,
  output logic [ach_pkg::DATA_W-1:0] resultData
);
  localparam int CW = $clog2(CONV_CYC + 1);
  localparam logic [CW-1:0] LOAD = CW'(CONV_CYC);
  localparam logic [CW-1:0] LAST = CW'(1);

  // Total pin-to-busy-rise time must stay inside the longest conversion
  if (CONV_CYC < 1 || SYNC_STAGES != ach_pkg::SYNC_STAGES)
  begin : g_bad_count
    $error("CONV_CYC or SYNC_STAGES out of range");
  end
  if (ach_pkg::EDGE_LAT + CONV_CYC > ach_pkg::CONV_MAX_CYC)
  begin : g_too_slow
    $error("conversion would exceed its longest time");
  end
  // Eight-bit run counters below must not wrap during a conversion
  if (CONV_CYC > 254)
  begin : g_run_width
    $error("CONV_CYC too large for the run counters");
  end

  logic startLevel;
  logic startFell;
  ach_pkg::ach_sample_s sample;
  ach_pkg::ach_state_e state;
  ach_pkg::ach_out_s outReg;
  logic [CW-1:0] count;
  logic [ach_pkg::DATA_W-1:0] heldCode;
  logic accept;
  logic finish;

  ach_start_sync u_sync (
    .clk(clk),
    .reset(reset),
    .pinN(conversionStartN),
    .level(startLevel),
    .fell(startFell)
  );

  ach_quantizer #(
    .DEPTH(SYNC_STAGES)
  ) u_quant (
    .clk(clk),
    .reset(reset),
    .analogLevel(analogLevel),
    .sample(sample)
  );

  // Converting decode shared by control and checks
  function automatic logic is_converting(input ach_pkg::ach_state_e s);
    return s == ach_pkg::ACH_CONVERT;
  endfunction : is_converting

  // Edges seen while converting simply drop out here
  assign accept = startFell && !is_converting(state);
  assign finish = is_converting(state) && (count == LAST);

  always_ff @(posedge clk)
  begin
    if (reset)
      state <= ach_pkg::ACH_ACQUIRE;
    else
    begin
      unique case (state)
        ach_pkg::ACH_ACQUIRE:
        begin
          if (accept)
            state <= ach_pkg::ACH_CONVERT;
        end
        ach_pkg::ACH_CONVERT:
        begin
          if (finish)
            state <= ach_pkg::ACH_ACQUIRE;
        end
      endcase
    end
  end

  // Internal conversion clock: fixed count, no external trim
  always_ff @(posedge clk)
  begin
    if (reset)
      count <= '0;
    else if (accept)
      count <= LOAD;
    else if (is_converting(state))
      count <= count - LAST;
  end

  // Code aligned to the pin edge, so the edge is the sampling instant
  always_ff @(posedge clk)
  begin
    if (reset)
      heldCode <= ach_pkg::RESULT_RST;
    else if (accept)
      heldCode <= sample.code;
  end

  // Bus changes only on the edge busy rises; no pipeline delay on the result
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      outReg.busyN <= ach_pkg::BUSY_IDLE;
      outReg.data <= ach_pkg::RESULT_RST;
    end
    else if (accept)
      outReg.busyN <= 1'b0;
    else if (finish)
    begin
      outReg.busyN <= 1'b1;
      outReg.data <= heldCode;
    end
  end

  // Outputs straight from flops; only these two outputs face the host
  assign busyN = outReg.busyN;
  assign resultData = outReg.data;

  // Helper: length of the current low phase of busy
  logic [7:0] lowRun;
  // Helper: cycles since busy last rose, saturating
  logic [7:0] highRun;
  // Helper: cycles since the last accepted start, saturating
  logic [7:0] acceptAge;
  // Helper: accepted starts still waiting for their busy rise
  logic [1:0] pending;

  always_ff @(posedge clk)
  begin
    if (reset)
      lowRun <= '0;
    else if (!outReg.busyN)
      lowRun <= lowRun + 8'h01;
    else
      lowRun <= '0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      highRun <= '0;
    else if (!outReg.busyN)
      highRun <= '0;
    else if (highRun != 8'hff)
      highRun <= highRun + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      acceptAge <= 8'hff;
    else if (accept)
      acceptAge <= '0;
    else if (acceptAge != 8'hff)
      acceptAge <= acceptAge + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      pending <= '0;
    else if (accept && !finish)
      pending <= pending + 2'h1;
    else if (finish && !accept)
      pending <= pending - 2'h1;
  end

  localparam int CONV_LEN = CONV_CYC;
  localparam int MAX_LOW = ach_pkg::CONV_MAX_CYC - ach_pkg::EDGE_LAT;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Reset and idle
  a_reset_idle: assert property (
    @(posedge clk) disable iff (1'b0)
    reset |=> busyN && resultData == ach_pkg::RESULT_RST)
    else $error("outputs not idle after reset");

  a_idle_quiet: assert property (
    !is_converting(state) && !accept |=> busyN)
    else $error("busy dropped without an accepted start");

  // Start acceptance
  a_accept_drop: assert property (
    startFell && !is_converting(state) |=> !busyN)
    else $error("accepted start did not drop busy");

  a_busy_fall_src: assert property (
    $fell(busyN) |-> $past(accept))
    else $error("busy fell without an accepted start");

  a_start_ignored: assert property (
    startFell && is_converting(state) && count > LAST
    |=> is_converting(state) && count == $past(count) - LAST)
    else $error("start during conversion disturbed it");

  a_refused_age: assert property (
    startFell && is_converting(state)
    |=> acceptAge == $past(acceptAge) + 8'h01)
    else $error("refused start restarted the conversion");

  a_one_pending: assert property (
    (pending <= 2'h1) && ((pending == 2'h1) == !busyN))
    else $error("more than one conversion in flight");

  a_sample_edge: assert property (
    accept |=> heldCode == $past(sample.code))
    else $error("sample not taken at the start edge");

  // Conversion timing
  a_count_load: assert property (
    accept |=> is_converting(state) && count == LOAD)
    else $error("conversion count not loaded on accept");

  a_busy_length: assert property (
    $rose(busyN) |-> lowRun == 8'(CONV_LEN))
    else $error("busy low phase has wrong length");

  a_busy_state: assert property (
    !busyN == is_converting(state))
    else $error("busy does not follow conversion state");

  a_conv_bound: assert property (
    $fell(busyN) |-> ##[1:MAX_LOW] busyN)
    else $error("busy did not rise within the longest conversion");

  a_conv_max: assert property (
    !busyN |-> lowRun < 8'(MAX_LOW))
    else $error("conversion running past its longest time");

  a_total_time: assert property (
    $rose(busyN) |-> acceptAge + 8'(ach_pkg::EDGE_LAT) <= 8'(ach_pkg::CONV_MAX_CYC))
    else $error("pin edge to busy rise too long");

  a_ready_again: assert property (
    $rose(busyN) |-> !is_converting(state) && highRun == 8'h00)
    else $error("not ready for next start after busy rose");

  // Result bus
  a_data_with_busy: assert property (
    $changed(resultData) |-> $rose(busyN))
    else $error("result changed away from busy rise");

  a_data_loaded: assert property (
    finish |=> busyN && resultData == $past(heldCode))
    else $error("result not loaded when busy rose");

  a_data_stable: assert property (
    $rose(busyN) |=> $stable(resultData) [*2])
    else $error("result not stable after busy rose");

  a_hold_result: assert property (
    !busyN && !$past(busyN) |-> $stable(resultData))
    else $error("result moved during conversion");

  // Main scenarios
  c_conversion: cover property ($fell(busyN) ##[1:40] $rose(busyN));
  c_ignored_start: cover property (startFell && is_converting(state));
  c_back_to_back: cover property ($rose(busyN) ##[1:20] $fell(busyN));
  c_clamped_code: cover property (accept && sample.clamped);
  c_top_code: cover property (finish && heldCode == 14'h1fff);
endmodule : ach_core
`default_nettype wire

/* tb/ach_host_model.sv */
// Host model: pulls the start pin, offers a level, latches the result.
// Assumes it is driven from the bench clock; drives its pins on falling edges.
`timescale 1ns/1ps
`default_nettype none
module ach_host_model (
  input wire logic clk,
  input wire logic busyN,
  input wire logic [ach_pkg::DATA_W-1:0] resultData,
  output logic conversionStartN,
  output logic signed [ach_pkg::LEVEL_W-1:0] analogLevel
);
  logic [ach_pkg::DATA_W-1:0] word;
  logic [ach_pkg::DATA_W-1:0] riseWord;
  logic [ach_pkg::DATA_W-1:0] atFall;
  logic [ach_pkg::DATA_W-1:0] atStartRise;
  logic held;
  int total;
  int lowCnt;
  int firstLow;

  initial
  begin
    conversionStartN = 1'b1;
    analogLevel = '0;
  end

  task automatic convert(input logic signed [ach_pkg::LEVEL_W-1:0] lvl, input bit retrig);
    logic [ach_pkg::DATA_W-1:0] prev;
    prev = resultData;
    total = 0;
    lowCnt = 0;
    firstLow = 0;
    held = 1'b1;
    @(negedge clk);
    conversionStartN = 1'b0;
    analogLevel = lvl;
    while (!(lowCnt > 0 && busyN === 1'b1) && total < 60)
    begin
      @(negedge clk);
      total++;
      // Level moves every cycle so only the start edge sample counts
      analogLevel = ~analogLevel;
      if (total == 4)
      begin
        atStartRise = resultData;
        conversionStartN = 1'b1;
      end
      if (retrig && total == 15)
        conversionStartN = 1'b0;
      if (retrig && total == 20)
        conversionStartN = 1'b1;
      if (busyN === 1'b0)
      begin
        lowCnt++;
        if (firstLow == 0)
        begin
          firstLow = total;
          atFall = resultData;
        end
        if (resultData !== prev)
          held = 1'b0;
      end
    end
    riseWord = resultData;
    repeat (ach_pkg::VALID_CYC) @(negedge clk);
    word = resultData;
    // Acquisition gap also keeps start spacing above the throughput time
    repeat (ach_pkg::ACQ_CYC - ach_pkg::VALID_CYC) @(negedge clk);
  endtask : convert
endmodule : ach_host_model
`default_nettype wire

/* tb/tb_adc_conversion_handshake.sv */
// Self-checking bench for the conversion handshake core.
// Assumes the host model drives the pins; the bench drives clock and reset.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_conversion_handshake;
  logic clk;
  logic reset;
  logic conversionStartN;
  logic signed [ach_pkg::LEVEL_W-1:0] analogLevel;
  logic busyN;
  logic [ach_pkg::DATA_W-1:0] resultData;
  int bad_count;
  int total_checks;
  int lvls[9] = '{48, 8, 7, -8, -9, -131072, -131064, 200000, -200000};

  ach_core i_dut (
    .clk(clk),
    .reset(reset),
    .conversionStartN(conversionStartN),
    .analogLevel(analogLevel),
    .busyN(busyN),
    .resultData(resultData)
  );

  ach_host_model i_host (
    .clk(clk),
    .busyN(busyN),
    .resultData(resultData),
    .conversionStartN(conversionStartN),
    .analogLevel(analogLevel)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [ach_pkg::DATA_W-1:0] exp_code(input int lvl);
    int q;
    q = (lvl + 8) >>> 4;
    if (q > 8191)
      q = 8191;
    if (q < -8192)
      q = -8192;
    return q[ach_pkg::DATA_W-1:0];
  endfunction : exp_code

  task automatic check_word(input logic [ach_pkg::DATA_W-1:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_count(input int got, exp);
    total_checks++;
    if (got != exp)
    begin
      bad_count++;
      $display("[ERR] %0t count got %h exp %h", $time, got, exp);
    end
  endtask : check_count

  task automatic check_flag(input logic got, exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t flag got %h exp %h", $time, got, exp);
    end
  endtask : check_flag

  task automatic complete_run;
    $display("bad_count %0d total_checks %0d", bad_count, total_checks);
    if (bad_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic test_reset;
    check_flag(busyN, ach_pkg::BUSY_IDLE);
    check_word(resultData, ach_pkg::RESULT_RST);
  endtask : test_reset

  task automatic test_timing;
    i_host.convert(19'sh0_0030, 1'b0);
    check_count(i_host.firstLow, ach_pkg::EDGE_LAT);
    check_count(i_host.lowCnt, ach_pkg::CONV_CYC);
    check_count(i_host.total, ach_pkg::EDGE_LAT + ach_pkg::CONV_CYC);
    check_flag(i_host.total <= ach_pkg::CONV_MAX_CYC, 1'b1);
    check_flag(i_host.held, 1'b1);
    check_word(i_host.riseWord, 14'h0003);
    check_word(i_host.word, 14'h0003);
  endtask : test_timing

  task automatic test_prev_capture;
    // Old word must still be on the bus at both early capture points
    i_host.convert(-19'sh0_0050, 1'b0);
    check_word(i_host.atFall, 14'h0003);
    check_word(i_host.atStartRise, 14'h0003);
    check_word(i_host.word, 14'h3FFB);
  endtask : test_prev_capture

  task automatic test_retrigger;
    i_host.convert(19'sh0_0100, 1'b1);
    check_count(i_host.lowCnt, ach_pkg::CONV_CYC);
    check_count(i_host.total, ach_pkg::EDGE_LAT + ach_pkg::CONV_CYC);
    check_word(i_host.word, 14'h0010);
  endtask : test_retrigger

  task automatic test_codes;
    foreach (lvls[i])
    begin
      i_host.convert(19'(lvls[i]), 1'b0);
      check_word(i_host.word, exp_code(lvls[i]));
      check_word(i_host.riseWord, exp_code(lvls[i]));
    end
  endtask : test_codes

  initial
  begin
    bad_count = 0;
    total_checks = 0;
    reset = 1'b1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    test_reset();
    test_timing();
    test_prev_capture();
    test_retrigger();
    test_codes();
    complete_run();
  end

  initial
  begin
    // Twelve conversions of about fifty cycles each, with ample margin
    #50000;
    bad_count++;
    complete_run();
  end
endmodule : tb_adc_conversion_handshake
`default_nettype wire
